/* File: common/eag_map.svh */
// offsets, field positions and limits of the effective address generator
`ifndef EAG_MAP_SVH
`define EAG_MAP_SVH

// register port offsets
`define EAG_OFF_CTRL 4'h0
`define EAG_OFF_LAST 4'h4
`define EAG_OFF_STAT 4'h8
`define EAG_CTRL_RST 1'h0
`define EAG_CTRL_MODE 0
// instruction word fields, the leftmost instruction bit is bit 15 here
`define EAG_BIT_I 15
`define EAG_BIT_X 14
`define EAG_BIT_S 9
`define EAG_D_HI 8
`define EAG_D_W 9
`define EAG_CLS_HI 1
// extended format marker in bits 9..4 (sector select included)
`define EAG_EXT_HI 9
`define EAG_EXT_LO 4
`define EAG_EXT_PAT 6'h30
// two-word segmented marker in bits 9..5, outside this block
`define EAG_V2W_LO 5
`define EAG_V2W_PAT 5'h18
// displacement limits
`define EAG_REG_LIM 9'h008
`define EAG_PRE_LIM 9'h040
`define EAG_LINK_LIM 9'h100
`define EAG_STACK_STEP 16'h0001

`endif

/* File: common/eag_pkg.sv */
// types of the effective address generator
package eag_pkg;

  typedef enum logic [1:0] {
    EAG_CLS_LONG = 2'h0,
    EAG_CLS_STACKREL = 2'h1,
    EAG_CLS_POSTINC = 2'h2,
    EAG_CLS_PREDEC = 2'h3
  } eag_class_t;

  typedef enum logic {
    EAG_MODE_WIDE_REL = 1'h0,
    EAG_MODE_SEG_VIRT = 1'h1
  } eag_mode_t;

endpackage

/* File: core/eag_effective_address_gen.sv */
// effective address generator for memory-reference instructions
//
// Contract
// - wide mode addresses are 16-bit words
// - sector select 0 forces sector bits zero; the indexed forms other than post-indexed add indexReg, so those bits can be nonzero
// - relative forms use program counter after fetch
// - short relative adds signed displacement to counter
// - class 2 uses stack pointer then increments
// - class 3 decrements stack pointer then uses
// - segmented procedure-relative adds displacement to counter
// - base-relative direct picks register, stack, link
// - base-relative indexed picks register, stack, link
// - base-relative indirect from register or procedure
// - indirect indexed pre or post by displacement
// - three separate base registers feed addresses
//
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "eag_map.svh"

module eag_effective_address_gen
  import eag_pkg::*;
#(
  parameter int AW = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [AW-1:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [AW-1:0] regRdData,
  // request
  input wire logic reqValid,
  input wire logic [15:0] instWord,
  input wire logic [AW-1:0] addrWord,
  input wire logic [AW-1:0] pcAfterFetch,
  input wire logic [AW-1:0] indexReg,
  input wire logic [AW-1:0] stackPointer,
  input wire logic [AW-1:0] procedureBase,
  input wire logic [AW-1:0] stackBase,
  input wire logic [AW-1:0] linkBase,
  // result
  output logic addrValid,
  output logic [AW-1:0] effectiveAddress,
  output logic regLoc,
  output logic indirect,
  output logic postIndex,
  output logic formatErr,
  output logic stackWrite,
  output logic [AW-1:0] stackNext
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  // the wide relative space is exactly 64K words
  if (AW != 16) begin : g_bad_aw
    $error("eag: AW must be 16");
  end

  // ----------------------------------------
  // field extraction
  // ----------------------------------------
  logic bitI;
  logic bitX;
  logic bitS;
  logic [`EAG_D_W-1:0] disp;
  eag_class_t classField;
  eag_mode_t mode;
  logic extFmt;
  logic twoWordSeg;
  logic [AW-1:0] dZero;
  logic [AW-1:0] dSigned;

  assign bitI = instWord[`EAG_BIT_I];
  assign bitX = instWord[`EAG_BIT_X];
  assign bitS = instWord[`EAG_BIT_S];
  assign disp = instWord[`EAG_D_HI:0];
  assign classField = eag_class_t'(instWord[`EAG_CLS_HI:0]);
  assign dZero = {{(AW-`EAG_D_W){1'b0}}, disp};
  assign dSigned = {{(AW-`EAG_D_W){disp[`EAG_D_HI]}}, disp};
  assign extFmt = (instWord[`EAG_EXT_HI:`EAG_EXT_LO] == `EAG_EXT_PAT);
  assign twoWordSeg = (instWord[`EAG_EXT_HI:`EAG_V2W_LO] == `EAG_V2W_PAT);

  // ----------------------------------------
  // control register
  // ----------------------------------------
  logic modeSeg_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      modeSeg_ff <= `EAG_CTRL_RST;
    end else if (regWr && regAddr == `EAG_OFF_CTRL) begin
      modeSeg_ff <= regWrData[`EAG_CTRL_MODE];
    end
  end

  assign mode = eag_mode_t'(modeSeg_ff);

  // ----------------------------------------
  // address calculation
  // ----------------------------------------
  logic [AW-1:0] nxt_addr;
  logic nxt_reg;
  logic nxt_ind;
  logic nxt_post;
  logic nxt_err;
  logic nxt_stackWr;
  logic [AW-1:0] nxt_stack;
  logic [AW-1:0] dPlusX;

  // small sum used for the register window test
  assign dPlusX = dZero + indexReg;

  always_comb begin
    nxt_addr = '0;
    nxt_reg = 1'b0;
    nxt_ind = bitI;
    nxt_post = 1'b0;
    nxt_err = 1'b0;
    nxt_stackWr = 1'b0;
    nxt_stack = stackPointer;
    if (mode == EAG_MODE_WIDE_REL) begin
      // all wide sums wrap inside 16 bits
      if (!bitS) begin
        nxt_addr = dZero;
        if (bitX && (!bitI || disp < `EAG_PRE_LIM)) begin
          nxt_addr = dPlusX;
        end
        nxt_post = bitI && bitX && disp >= `EAG_PRE_LIM;
      end else if (extFmt) begin
        // second word drives long reach and stack relative
        case (classField)
          EAG_CLS_LONG: begin
            nxt_addr = (bitX && !bitI) ? addrWord + indexReg : addrWord;
            nxt_post = bitI && bitX;
          end
          EAG_CLS_STACKREL: begin
            nxt_addr = addrWord + stackPointer;
            if (bitX) begin
              nxt_addr = addrWord + stackPointer + indexReg;
            end
          end
          EAG_CLS_POSTINC: begin
            nxt_addr = stackPointer;
            nxt_ind = bitI || bitX;
            nxt_post = bitX;
            nxt_stackWr = 1'b1;
            nxt_stack = stackPointer + `EAG_STACK_STEP;
          end
          default: begin
            nxt_addr = stackPointer - `EAG_STACK_STEP;
            nxt_ind = bitI || bitX;
            nxt_post = bitX;
            nxt_stackWr = 1'b1;
            nxt_stack = stackPointer - `EAG_STACK_STEP;
          end
        endcase
      end else begin
        // counter already points past the instruction
        nxt_addr = pcAfterFetch + dSigned;
        if (bitX && !bitI) begin
          nxt_addr = pcAfterFetch + dSigned + indexReg;
        end
        nxt_post = bitI && bitX;
      end
    end else begin
      if (bitS) begin
        if (twoWordSeg) begin
          // two-word segmented form is handled elsewhere
          nxt_err = 1'b1;
          nxt_ind = 1'b0;
        end else begin
          nxt_addr = pcAfterFetch + dSigned;
          if (bitX && !bitI) begin
            nxt_addr = pcAfterFetch + dSigned + indexReg;
          end
          nxt_post = bitI && bitX;
        end
      end else if (!bitI && !bitX) begin
        if (disp < `EAG_REG_LIM) begin
          nxt_addr = dZero;
          nxt_reg = 1'b1;
        end else if (disp < `EAG_LINK_LIM) begin
          nxt_addr = stackBase + dZero;
        end else begin
          nxt_addr = linkBase + dZero;
        end
      end else if (!bitI) begin
        if (disp >= `EAG_LINK_LIM) begin
          nxt_addr = linkBase + dPlusX;
        end else if (dPlusX < AW'(`EAG_REG_LIM)) begin
          nxt_addr = dPlusX;
          nxt_reg = 1'b1;
        end else begin
          nxt_addr = stackBase + dPlusX;
        end
      end else if (!bitX) begin
        // indirect word from register or procedure
        if (disp < `EAG_REG_LIM) begin
          nxt_addr = dZero;
          nxt_reg = 1'b1;
        end else begin
          nxt_addr = procedureBase + dZero;
        end
      end else begin
        if (disp < `EAG_PRE_LIM) begin
          nxt_addr = procedureBase + dPlusX;
        end else begin
          nxt_addr = procedureBase + dZero;
          nxt_post = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // result registers
  // ----------------------------------------
  logic addrValid_ff;
  logic [AW-1:0] effAddr_ff;
  logic regLoc_ff;
  logic indirect_ff;
  logic postIndex_ff;
  logic formatErr_ff;
  logic stackWrite_ff;
  logic [AW-1:0] stackNext_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      addrValid_ff <= 1'b0;
    end else begin
      addrValid_ff <= reqValid;
    end
  end

  // data hold their value between requests for the sequencer
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      effAddr_ff <= '0;
      regLoc_ff <= 1'b0;
      indirect_ff <= 1'b0;
      postIndex_ff <= 1'b0;
      formatErr_ff <= 1'b0;
      stackNext_ff <= '0;
    end else if (reqValid) begin
      effAddr_ff <= nxt_addr;
      regLoc_ff <= nxt_reg;
      indirect_ff <= nxt_ind;
      postIndex_ff <= nxt_post;
      formatErr_ff <= nxt_err;
      stackNext_ff <= nxt_stack;
    end
  end

  // stack pointer write is a pulse so it can never be applied twice
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stackWrite_ff <= 1'b0;
    end else begin
      stackWrite_ff <= reqValid && nxt_stackWr;
    end
  end

  assign addrValid = addrValid_ff;
  assign effectiveAddress = effAddr_ff;
  assign regLoc = regLoc_ff;
  assign indirect = indirect_ff;
  assign postIndex = postIndex_ff;
  assign formatErr = formatErr_ff;
  assign stackWrite = stackWrite_ff;
  assign stackNext = stackNext_ff;

  // ----------------------------------------
  // register read
  // ----------------------------------------
  logic [AW-1:0] rdData_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_ff <= '0;
    end else if (regRd) begin
      if (regAddr == `EAG_OFF_CTRL) begin
        rdData_ff <= {{(AW-1){1'b0}}, modeSeg_ff};
      end else if (regAddr == `EAG_OFF_LAST) begin
        rdData_ff <= effAddr_ff;
      end else if (regAddr == `EAG_OFF_STAT) begin
        rdData_ff <= {{(AW-4){1'b0}}, formatErr_ff, postIndex_ff, indirect_ff, regLoc_ff};
      end else begin
        rdData_ff <= '0;
      end
    end else begin
      rdData_ff <= '0;
    end
  end

  assign regRdData = rdData_ff;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking clkDef @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_wide_req;
    reqValid && !modeSeg_ff && !(regWr && regAddr == `EAG_OFF_CTRL);
  endsequence

  sequence s_seg_base_req;
    reqValid && modeSeg_ff && !bitS;
  endsequence

  a_valid_strobe: assert property (reqValid |=> addrValid ##0 (!addrValid || $past(reqValid, 1)))
    else $error("valid strobe not one cycle after request");
  a_no_spurious: assert property (!reqValid |=> !addrValid)
    else $error("valid without request");
  a_sector_zero: assert property (s_wide_req ##0 (!bitS && !bitX) |=> effAddr_ff == $past(dZero))
    else $error("sector zero address wrong");
  a_rel_direct: assert property (s_wide_req ##0 (bitS && !extFmt && !bitX)
      |=> effAddr_ff == $past(pcAfterFetch) + $past(dSigned))
    else $error("relative address wrong");
  a_post_inc: assert property (s_wide_req ##0 (extFmt && classField == EAG_CLS_POSTINC)
      |=> stackWrite && effAddr_ff == $past(stackPointer)
      && stackNext == $past(stackPointer) + `EAG_STACK_STEP)
    else $error("postincrement wrong");
  a_pre_dec: assert property (s_wide_req ##0 (extFmt && classField == EAG_CLS_PREDEC)
      |=> stackWrite && effAddr_ff == stackNext && stackNext == $past(stackPointer) - `EAG_STACK_STEP)
    else $error("predecrement wrong");
  // indexed forms may leave the register window, so only the direct form is held here
  a_base_reg: assert property (s_seg_base_req ##0 (!bitI && !bitX && disp < `EAG_REG_LIM)
      |=> regLoc && effAddr_ff == $past(dZero))
    else $error("register location missed");
  a_link_base: assert property (s_seg_base_req ##0 (!bitI && !bitX && disp >= `EAG_LINK_LIM)
      |=> !regLoc && effAddr_ff == $past(linkBase) + $past(dZero))
    else $error("link base address wrong");
  a_post_index: assert property (s_seg_base_req ##0 (bitI && bitX && disp >= `EAG_PRE_LIM)
      |=> postIndex && indirect && effAddr_ff == $past(procedureBase) + $past(dZero))
    else $error("postindex form wrong");

endmodule

/* File: dv/eag_seq_model.sv */
// sequencer model holding the stack pointer that the generator updates
`timescale 1ns/100ps

module eag_seq_model
  import eag_pkg::*;
#(
  parameter logic [15:0] STACK_INIT = 16'h1000
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // update request from the generator
  input wire logic stackWrite,
  input wire logic [15:0] stackNext,
  // value presented to the generator
  output logic [15:0] stackPointer
);
  logic [15:0] stackPtr_ff;

  // ----------------------------------------
  // stack pointer register
  // ----------------------------------------
  // apply stack update
  // the update lands one edge after the result, so a request issued back to back sees the old value
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stackPtr_ff <= STACK_INIT;
    end else if (stackWrite) begin
      stackPtr_ff <= stackNext;
    end
  end

  assign stackPointer = stackPtr_ff;
endmodule

/* File: dv/test_eag_effective_address_gen.sv */
// self-checking bench for the effective address generator
`timescale 1ns/100ps
`include "eag_map.svh"

module test_eag_effective_address_gen
  import eag_pkg::*;
;
  logic clk_sys = 1'h0;
  logic rst_n = 1'h0;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, rdVal;
  logic regWr, regRd, reqValid;
  logic [15:0] instWord, addrWord, pcAfterFetch, indexReg, stackPointer;
  logic [15:0] procedureBase, stackBase, linkBase, effectiveAddress, stackNext;
  logic addrValid, regLoc, indirect, postIndex, formatErr, stackWrite;
  int miscompares = 0;
  int numChecks = 0;
  // rows: instruction, address word, expected address, flags {skip address, formatErr, postIndex, indirect, regLoc}
  logic [63:0] tab [22];

  always #2 clk_sys = ~clk_sys;

  eag_effective_address_gen DUT (
    .clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .reqValid(reqValid), .instWord(instWord), .addrWord(addrWord),
    .pcAfterFetch(pcAfterFetch), .indexReg(indexReg), .stackPointer(stackPointer),
    .procedureBase(procedureBase), .stackBase(stackBase), .linkBase(linkBase), .addrValid(addrValid),
    .effectiveAddress(effectiveAddress), .regLoc(regLoc), .indirect(indirect), .postIndex(postIndex),
    .formatErr(formatErr), .stackWrite(stackWrite), .stackNext(stackNext)
  );

  eag_seq_model SEQ (
    .clk_sys(clk_sys), .rst_n(rst_n), .stackWrite(stackWrite), .stackNext(stackNext),
    .stackPointer(stackPointer)
  );

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    numChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic regWrite(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regWr <= 1'h1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'h0;
  endtask

  task automatic rdChk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    regRd <= 1'h1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'h0;
    #1;
    rdVal = regRdData;
    chk(nm, exp, rdVal);
  endtask

  // result is looked at in the single cycle that addrValid stands
  task automatic issue(input logic [15:0] iw, input logic [15:0] aw);
    @(posedge clk_sys);
    reqValid <= 1'h1;
    instWord <= iw;
    addrWord <= aw;
    @(posedge clk_sys);
    reqValid <= 1'h0;
    #1;
    chk("addrValid", 16'h0001, {15'h0000, addrValid});
  endtask

  task automatic wrapUp;
    $display("checks %0d mismatches %0d", numChecks, miscompares);
    if (miscompares == 0 && numChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #40000;
    miscompares++;
    wrapUp();
  end

  initial begin
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'h0;
    regRd = 1'h0;
    reqValid = 1'h0;
    instWord = 16'h0000;
    addrWord = 16'h0000;
    pcAfterFetch = 16'hA5F0;
    indexReg = 16'h0004;
    procedureBase = 16'h2000;
    stackBase = 16'h4000;
    linkBase = 16'h8000;
    tab = '{64'h01FF_0000_01FF_0000, 64'hC03F_0000_0043_0002, 64'hC040_0000_0040_0006,
      64'h02FF_0000_A6EF_0000, 64'h0310_0000_A500_0000, 64'h4310_0000_A504_0000, 64'h8210_0000_A600_0002,
      64'h4300_1234_1238_0000, 64'h0301_0010_1011_0000, 64'h0005_0000_0005_0001, 64'h0008_0000_4008_0000,
      64'h00FF_0000_40FF_0000, 64'h0100_0000_8100_0000, 64'h4003_0000_0007_0001, 64'h4004_0000_4008_0000,
      64'h4100_0000_8104_0000, 64'h8007_0000_0007_0003, 64'h8008_0000_2008_0002, 64'hC03F_0000_2043_0002,
      64'hC040_0000_2040_0006, 64'h0320_0000_A510_0000, 64'h0300_0000_0000_0008};
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'h1;
    rdChk("mode", `EAG_OFF_CTRL, 16'h0000);
    $display("test reset done");
    // stack forms with an idle cycle between requests, so the model has updated its pointer
    issue(16'h0302, 16'h0000);
    chk("address", 16'h1000, effectiveAddress);
    chk("stackWrite", 16'h0001, {15'h0000, stackWrite});
    chk("stackNext", 16'h1001, stackNext);
    @(posedge clk_sys);
    #1;
    chk("stackWrite", 16'h0000, {15'h0000, stackWrite});
    chk("addrValid", 16'h0000, {15'h0000, addrValid});
    chk("stackPointer", 16'h1001, stackPointer);
    issue(16'h0303, 16'h0000);
    chk("address", 16'h1000, effectiveAddress);
    chk("stackNext", 16'h1000, stackNext);
    issue(16'h4302, 16'h0000);
    chk("address", 16'h1000, effectiveAddress);
    chk("flags", 16'h0006, {12'h000, formatErr, postIndex, indirect, regLoc});
    rdChk("last", `EAG_OFF_LAST, 16'h1000);
    $display("test stack done");
    // table of addressing forms, segmented mode from row 9
    for (int i = 0; i < 22; i++) begin
      if (i == 9) begin
        regWrite(`EAG_OFF_CTRL, 16'h0001);
        rdChk("mode", `EAG_OFF_CTRL, 16'h0001);
      end
      issue(tab[i][63:48], tab[i][47:32]);
      if (tab[i][15] === 1'h0) begin
        chk("address", tab[i][31:16], effectiveAddress);
      end
      chk("flags", {12'h000, tab[i][3:0]}, {12'h000, formatErr, postIndex, indirect, regLoc});
    end
    $display("test forms done");
    rdChk("status", `EAG_OFF_STAT, 16'h0008);
    rdChk("unmapped", 4'hC, 16'h0000);
    $display("test registers done");
    wrapUp();
  end
endmodule
